// File: design/wdis_counter.v
// Purpose: 32-bit down counter with reload and stall.
// Assumes: Reload wins over counting.
// Notes:   Zero pulse is one cycle when the count reaches zero.
`timescale 1ns/1ns
`include "wdis_regs.vh"
module wdis_counter (
  // Clock and reset
  input  wire        mclk,
  input  wire        reset,
  // Control
  input  wire        run,
  input  wire        stall,
  input  wire        reload,
  input  wire [31:0] reloadValue,
  // Status
  output wire [31:0] count,
  output wire        zeroHit
);
  reg [31:0] count_ff;
  reg        zero_ff;
  reg [31:0] nxt_count;
  reg        nxt_zero;
  // ----------------------------------------
  // Countdown
  // ----------------------------------------
  always @* begin
    nxt_count = count_ff;
    nxt_zero  = 1'b0;
    if (reload) begin
      nxt_count = reloadValue;
      nxt_zero  = (reloadValue == `WDIS_ZERO32);
    end else if (run && !stall) begin
      if (count_ff == `WDIS_ZERO32) begin
        nxt_count = reloadValue; // Wrap to start a fresh interval
      end else begin
        nxt_count = count_ff - `WDIS_ONE32;
        nxt_zero  = (count_ff == `WDIS_ONE32);
      end
    end
  end
  always @(posedge mclk) begin
    if (reset) begin
      count_ff <= `WDIS_LOAD_RESET;
      zero_ff  <= 1'b0;
    end else begin
      count_ff <= nxt_count;
      zero_ff  <= nxt_zero;
    end
  end
  assign count   = count_ff;
  assign zeroHit = zero_ff;
endmodule // wdis_counter

// File: design/wdis_regs.vh
// Purpose: Constants for the watchdog status and stall block.
// Assumes: 32-bit APB data, byte offsets.
// Notes:   Definitions only.
`ifndef WDIS_REGS_VH
`define WDIS_REGS_VH
`define WDIS_OFF_RAW      12'h010
`define WDIS_OFF_MASKED   12'h014
`define WDIS_OFF_TEST     12'h418
`define WDIS_OFF_LOAD     12'h000
`define WDIS_OFF_CTRL     12'h008
`define WDIS_OFF_CLEAR    12'h00C
`define WDIS_BIT_RAW      0
`define WDIS_BIT_MASKED   0
`define WDIS_BIT_STALL    8
`define WDIS_BIT_IRQEN    0
`define WDIS_BIT_RESEN    1
`define WDIS_LOAD_RESET   32'hFFFFFFFF
`define WDIS_ZERO32       32'h00000000
`define WDIS_ONE32        32'h00000001
`define WDIS_CTRL_MASK    32'h00000003
`define WDIS_TEST_MASK    32'h00000100
`endif

// File: design/wdis_sync.v
// Purpose: Two-flop synchroniser for a level.
// Assumes: Synchronous active-high reset.
// Notes:   First stage feeds only the second.
`timescale 1ns/1ns
module wdis_sync (
  // Clock and reset
  input  wire mclk,
  input  wire reset,
  // Level
  input  wire din,
  output wire dout
);
  reg stage1_ff;
  reg stage2_ff;
  // ----------------------------------------
  // Two stages
  // ----------------------------------------
  always @(posedge mclk) begin
    if (reset) begin
      stage1_ff <= 1'b0;
      stage2_ff <= 1'b0;
    end else begin
      stage1_ff <= din;
      stage2_ff <= stage1_ff;
    end
  end
  assign dout = stage2_ff;
endmodule // wdis_sync

// File: design/wdis_top.v
// Purpose: Watchdog raw/masked interrupt status and debug stall, APB slave.
// Assumes: One clock mclk at 50 MHz, synchronous active-high reset.
// Notes:   Counter and load/control kept minimal to drive the status logic.
// Contract
// R1 - Raw status bit 0 is read-only and shows time-out state before masking.
// R2 - Raw status stays readable and pending even when the interrupt is masked.
// R3 - Masked status bit 0 is raw status AND the interrupt enable bit.
// R4 - The interrupt output carries the masked status.
// R5 - Masked status resets to 0 and bits 31:1 of both status registers read 0.
// R6 - With the stall bit set and the processor halted, counting stops, resuming when it runs.
// R7 - Software does not depend on reserved bit values.
// R8 - Software preserves reserved bits on read-modify-write.
// R9 - Any write to the clear register clears the interrupt and reloads the counter; a time-out in the clear cycle keeps raw status set.
// R10 - Writing a load value of zero raises the interrupt at once.
// R11 - Once interrupt enable is set, control writes are ignored until reset.
// R12 - Raw status sets when the count reaches zero and holds until cleared.
//
// Our own choice: the APB register port.
`timescale 1ns/1ns
`include "wdis_regs.vh"
module wdis_top (
  // Clock and reset
  input  wire        mclk,
  input  wire        reset,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output wire        pslverr,
  output wire [31:0] prdata,
  // Debug halt from the processor, asynchronous
  input  wire        cpuHalted,
  // Interrupt
  output wire        timeoutIrqOut
);
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  reg  [31:0] reloadValue_ff;
  reg         irqEnable_ff;
  reg         resetEnable_ff;
  reg         stall_ff;
  reg         rawIrqState_ff;
  reg  [31:0] prdata_ff;
  reg         pslverr_ff;
  reg  [31:0] nxt_prdata;
  reg         nxt_err;
  wire        haltSync;
  wire        zeroHit;
  wire        wrAccess;
  wire        rdAccess;
  wire        clearWr;
  wire        loadWr;
  wire        maskedIrqState;

  // Register decode, used for reads and writes
  function isMapped;
    input [11:0] a;
    begin
      isMapped = (a == `WDIS_OFF_LOAD) || (a == `WDIS_OFF_CTRL) || (a == `WDIS_OFF_CLEAR) ||
                 (a == `WDIS_OFF_RAW) || (a == `WDIS_OFF_MASKED) || (a == `WDIS_OFF_TEST);
    end
  endfunction

  // Zero-wait slave: every access completes in its first access cycle
  assign pready   = 1'b1;
  assign wrAccess = psel && penable && pwrite;
  assign rdAccess = psel && !penable && !pwrite; // Data registered during setup
  assign clearWr  = wrAccess && (paddr == `WDIS_OFF_CLEAR);
  assign loadWr   = wrAccess && (paddr == `WDIS_OFF_LOAD);

  // ----------------------------------------
  // Halt synchroniser
  // ----------------------------------------
  wdis_sync u_haltSync (
    .mclk  (mclk),
    .reset (reset),
    .din   (cpuHalted),
    .dout  (haltSync)
  );

  // ----------------------------------------
  // Counter
  // ----------------------------------------
  // Runs only once enabled; halt freezes it only when stall is set
  wdis_counter u_counter (
    .mclk        (mclk),
    .reset       (reset),
    .run         (irqEnable_ff),
    .stall       (stall_ff && haltSync), // [R6]
    .reload      (clearWr || loadWr), // [R9]
    .reloadValue (loadWr ? pwdata : reloadValue_ff),
    .count       (),
    .zeroHit     (zeroHit)
  );

  // ----------------------------------------
  // Writable registers
  // ----------------------------------------
  always @(posedge mclk) begin
    if (reset) begin
      reloadValue_ff <= `WDIS_LOAD_RESET;
      irqEnable_ff   <= 1'b0;
      resetEnable_ff <= 1'b0;
      stall_ff       <= 1'b0;
    end else begin
      if (loadWr) begin
        reloadValue_ff <= pwdata;
      end
      // Enable locks the control register until reset
      if (wrAccess && (paddr == `WDIS_OFF_CTRL) && !irqEnable_ff) begin // [R11]
        irqEnable_ff   <= pwdata[`WDIS_BIT_IRQEN];
        resetEnable_ff <= pwdata[`WDIS_BIT_RESEN];
      end
      if (wrAccess && (paddr == `WDIS_OFF_TEST)) begin
        stall_ff <= pwdata[`WDIS_BIT_STALL]; // [R6]
      end
    end
  end

  // ----------------------------------------
  // Raw status
  // ----------------------------------------
  // Set wins over clear so a time-out in the clear cycle is not lost
  always @(posedge mclk) begin
    if (reset) begin
      rawIrqState_ff <= 1'b0;
    end else if (zeroHit) begin
      rawIrqState_ff <= 1'b1; // [R12] [R10]
    end else if (clearWr) begin
      rawIrqState_ff <= 1'b0; // [R9]
    end
  end

  // Masked state and interrupt output
  assign maskedIrqState = rawIrqState_ff && irqEnable_ff; // [R3]
  // No extra gating: the pin must always agree with the masked status read
  assign timeoutIrqOut  = maskedIrqState; // [R4]

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  // Reserved bits are forced to zero on read
  always @* begin
    nxt_prdata = `WDIS_ZERO32;
    nxt_err    = 1'b0;
    case (paddr)
      `WDIS_OFF_LOAD:   nxt_prdata = reloadValue_ff;
      `WDIS_OFF_CTRL:   nxt_prdata = {30'h0, resetEnable_ff, irqEnable_ff};
      `WDIS_OFF_RAW:    nxt_prdata[`WDIS_BIT_RAW] = rawIrqState_ff; // [R1] [R2] [R5]
      `WDIS_OFF_MASKED: nxt_prdata[`WDIS_BIT_MASKED] = maskedIrqState; // [R3] [R5]
      `WDIS_OFF_TEST:   nxt_prdata[`WDIS_BIT_STALL] = stall_ff;
      default:          nxt_prdata = `WDIS_ZERO32;
    endcase
    if (!isMapped(paddr)) begin
      nxt_err = 1'b1;
    end
  end

  // Captured at setup so data is valid during the access phase
  always @(posedge mclk) begin
    if (reset) begin
      prdata_ff  <= `WDIS_ZERO32;
      pslverr_ff <= 1'b0;
    end else if (psel && !penable) begin
      prdata_ff  <= rdAccess ? nxt_prdata : `WDIS_ZERO32;
      pslverr_ff <= nxt_err;
    end
  end

  assign prdata  = prdata_ff;
  assign pslverr = pslverr_ff && psel && penable;
endmodule // wdis_top

// File: tb/wdis_properties.sv
// Purpose: Port-level properties of the watchdog status and stall block.
// Assumes: Zero-wait APB, synchronous active-high reset.
// Notes:   Bound to wdis_top below the module.
`timescale 1ns/1ns
module wdis_properties (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        reset,
  // APB and interrupt
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        timeoutIrqOut
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  chk_ready_access: assert property (psel && penable |-> pready)
    else $error("pready low in access phase");
  chk_err_idle: assert property (!(psel && penable) |-> !pslverr)
    else $error("pslverr outside access phase");
  chk_irq_reset: assert property ($fell(reset) |-> !timeoutIrqOut)
    else $error("interrupt high after reset");
  chk_clear_drops: assert property (psel && penable && pwrite && paddr == 12'h00C |=> !timeoutIrqOut)
    else $error("interrupt not cleared");
  chk_raw_resv: assert property (psel && penable && !pwrite && paddr == 12'h010 |-> prdata[31:1] == 31'h0)
    else $error("raw status reserved bits set");
  chk_mis_resv: assert property (psel && penable && !pwrite && paddr == 12'h014 |-> prdata[31:1] == 31'h0)
    else $error("masked status reserved bits set");
  chk_test_resv: assert property (psel && penable && !pwrite && paddr == 12'h418 |-> {prdata[31:9], prdata[7:0]} == 31'h0)
    else $error("test register reserved bits set");
  chk_unmapped_err: assert property (psel && penable && paddr == 12'h030 |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  // Read data were captured at the setup edge, so compare with the pin as sampled there
  chk_irq_masked: assert property (psel && penable && !pwrite && paddr == 12'h014 |->
    prdata[0] == $past(timeoutIrqOut))
    else $error("interrupt differs from masked status");
endmodule // wdis_properties

bind wdis_top wdis_properties u_props (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .timeoutIrqOut(timeoutIrqOut));

// File: tb/wdis_top_tb.sv
// Purpose: Self-checking bench for the watchdog status and stall block.
// Assumes: 50 MHz mclk, reset held 20 cycles.
// Notes:   Small integer model predicts the raw and masked status reads and the interrupt.
`timescale 1ns/1ns
`include "wdis_regs.vh"
module wdis_top_tb;
  logic        mclk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, cpuHalted = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd;
  logic        pready, pslverr, timeoutIrqOut, err;
  int          nFail = 0, testsRun = 0, seed = 99734, mRaw = 0, mEn = 0, k;
  wire [31:0]  prdata_w;
  wdis_top uut (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata_w), .cpuHalted(cpuHalted),
    .timeoutIrqOut(timeoutIrqOut));
  initial forever #10 mclk = ~mclk;
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic finishTest;
    if (nFail == 0 && testsRun > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    testsRun++;
    if (got !== exp) begin
      nFail++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask
  // One APB transfer; waits for pready with a bound, not a fixed count
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge mclk);
    penable <= 1;
    do begin @(posedge mclk); n++; end while (pready !== 1'b1 && n < 50);
    if (n >= 50) nFail++;
    rd = prdata_w;
    err = pslverr;
    psel <= 0; penable <= 0;
  endtask
  // Interrupt is predicted from the model after two masked status reads and after the time-out wait
  task automatic chkIrq;
    chk("irq", (mRaw & mEn), {31'h0, timeoutIrqOut});
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge mclk);
    reset <= 0;
    apb(0, `WDIS_OFF_RAW, 0); chk("raw", 0, rd);
    apb(0, `WDIS_OFF_MASKED, 0); chk("masked", 0, rd);
    apb(0, `WDIS_OFF_TEST, 0); chk("test", 0, rd);
    apb(0, 12'h030, 0); chk("slverr", 1, {31'h0, err});
    apb(1, `WDIS_OFF_TEST, 32'hFFFFFFFF);
    apb(0, `WDIS_OFF_TEST, 0); chk("test", `WDIS_TEST_MASK, rd);
    apb(1, `WDIS_OFF_LOAD, 0); mRaw = 1;
    repeat (3) @(posedge mclk);
    apb(0, `WDIS_OFF_RAW, 0); chk("raw", mRaw, rd);
    apb(0, `WDIS_OFF_MASKED, 0); chk("masked", mRaw & mEn, rd);
    chkIrq();
    apb(1, `WDIS_OFF_CTRL, 1); mEn = 1;
    apb(0, `WDIS_OFF_MASKED, 0); chk("masked", mRaw & mEn, rd);
    chkIrq();
    apb(1, `WDIS_OFF_CTRL, 0);
    apb(0, `WDIS_OFF_MASKED, 0); chk("masked", mRaw & mEn, rd);
    // Halt first so the two-flop lag has passed before the reload
    cpuHalted <= 1;
    apb(1, `WDIS_OFF_LOAD, 32'(5 + ({$random(seed)} % 16)));
    apb(1, `WDIS_OFF_CLEAR, 32'($random(seed))); mRaw = 0;
    apb(0, `WDIS_OFF_RAW, 0); chk("raw", mRaw, rd);
    repeat (40) @(posedge mclk);
    apb(0, `WDIS_OFF_RAW, 0); chk("raw", mRaw, rd);
    cpuHalted <= 0; mRaw = 1;
    k = 0;
    while (timeoutIrqOut !== 1'b1 && k < 60) begin @(posedge mclk); k++; end
    chkIrq();
    apb(0, `WDIS_OFF_RAW, 0); chk("raw", mRaw, rd);
    // Read-modify-write of the test register keeps whatever the reserved bits hold
    apb(0, `WDIS_OFF_TEST, 0);
    apb(1, `WDIS_OFF_TEST, rd & ~`WDIS_TEST_MASK);
    apb(0, `WDIS_OFF_TEST, 0); chk("stall", 0, rd & `WDIS_TEST_MASK);
    finishTest();
  end
  // Watchdog: the whole sequence needs well under 1000 cycles
  initial begin
    #(20 * 3000);
    nFail++;
    finishTest();
  end
endmodule // wdis_top_tb
